// ### common/timer0_defs.svh
// Notes on behaviour
// [R1] a count register write blocks the compare match on the next tick
// [R2] 8-bit compare value checked against the counter always; match sets flag, drives pin
// [R3] mask bit 1 enables the overflow request, with global enable and flag
// [R4] mask bit 0 enables the compare request, with global enable and flag
// [R5] overflow flag bit 1 sets on overflow, or on reversal at zero in phase-correct
// [R6] overflow flag clears on vector execution or on software writing one
// [R7] compare flag bit 0 sets on match, clears on vector or written one
// [R8] both timers share one prescaler, each with its own clock select
// [R9] clock select 1 counts on every system clock
// [R10] prescaler taps divide the system clock by 8, 64, 256 and 1024
// [R11] prescaler runs freely; first prescaled count comes 1 to N+1 cycles later
// [R12] writing one to bit 0 resets the prescaler; bit self-clears, reads zero
// [R13] count pins sampled once per system clock on the rising edge
// [R14] one tick per rising edge at select 7, per falling edge at 6
// [R15] pin edge to counter update takes 2.5 to 3.5 system cycles
// [R16] software changes external clock selection only while the pin is stable
// [R17] external clock half periods exceed one system cycle
// [R18] external pin pulses bypass the prescaler, never divided
// [R19] select 0 stops, 2 to 5 pick taps, 6 and 7 pin edges
// [R20] pin edges count even while the pin is used as an output
// [R21] each request is flag AND mask; global enable left to the processor
`ifndef TIMER0_DEFS_SVH
`define TIMER0_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_COUNT     8'h00
`define OFS_COMPARE   8'h04
`define OFS_MASK      8'h08
`define OFS_FLAGS     8'h0C
`define OFS_SFC       8'h10
`define OFS_T0_CTRL   8'h14
`define OFS_T1_CTRL   8'h18

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define BIT_CMP        0
`define BIT_OVF        1
`define BIT_PRES_RST   0
`define BIT_PHASE_PWM  3
`define RST_BYTE       8'h00
`define RST_PRES       10'h000
`define COUNT_MAX      8'hFF
`define COUNT_BOTTOM   8'h00
`define PRES_W         10

`endif

// ### common/timer0_pkg.sv
package timer0_pkg;

  // ----------------------------------------
  // clock select codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    CS_STOP   = 3'h0,
    CS_DIRECT = 3'h1,
    CS_DIV8   = 3'h2,
    CS_DIV64  = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1K  = 3'h5,
    CS_FALL   = 3'h6,
    CS_RISE   = 3'h7
  } clk_sel_e;

endpackage : timer0_pkg

// ### hdl/timer0_flags_prescaler.sv
// Design decisions made here: the register offsets and the APB register port.
`include "timer0_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module timer0_flags_prescaler (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        extCountPinA,
  input  wire logic        extCountPinB,
  input  wire logic        ovfVectorAck,
  input  wire logic        cmpVectorAck,
  output logic             ovfIrq,
  output logic             cmpIrq,
  output logic             compareOutputPin,
  output logic             timer1Tick
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic clkTick(
    input timer0_pkg::clk_sel_e     sel,
    input logic [`PRES_W-1:0]       pres,
    input logic                     rise,
    input logic                     fall
  );
    logic t;
    t = 1'b0;
    // [R19] select decode
    unique case (sel)
      timer0_pkg::CS_STOP:   t = 1'b0;
      // [R9] direct system clock
      timer0_pkg::CS_DIRECT: t = 1'b1;
      timer0_pkg::CS_DIV8:   t = &pres[2:0];
      timer0_pkg::CS_DIV64:  t = &pres[5:0];
      timer0_pkg::CS_DIV256: t = &pres[7:0];
      timer0_pkg::CS_DIV1K:  t = &pres[9:0];
      timer0_pkg::CS_FALL:   t = fall;
      timer0_pkg::CS_RISE:   t = rise;
    endcase
    return t;
  endfunction : clkTick

  function automatic logic addrMapped(input logic [7:0] a);
    return (a == `OFS_COUNT) || (a == `OFS_COMPARE) || (a == `OFS_MASK)
        || (a == `OFS_FLAGS) || (a == `OFS_SFC) || (a == `OFS_T0_CTRL)
        || (a == `OFS_T1_CTRL);
  endfunction : addrMapped

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [31:0]              prdata_ff;
  logic                     pready_ff;
  logic                     pslverr_ff;
  logic [7:0]               count_ff;
  logic [7:0]               compare_ff;
  logic [7:0]               mask_ff;
  logic                     ovfFlag_ff;
  logic                     cmpFlag_ff;
  logic                     countDown_ff;
  logic                     phasePwm_ff;
  logic                     blockMatch_ff;
  timer0_pkg::clk_sel_e     sel0_ff;
  timer0_pkg::clk_sel_e     sel1_ff;
  logic [`PRES_W-1:0]       pres_ff;
  logic [1:0]               pinS1_ff;
  logic [1:0]               pinS2_ff;
  logic [1:0]               pinS3_ff;
  logic                     ovfIrq_ff;
  logic                     cmpIrq_ff;
  logic                     cmpPin_ff;
  logic                     timer1Tick_ff;
  logic                     apbSetup;
  logic                     apbDone;
  logic                     apbWr;
  logic                     wrCount;
  logic                     wrFlags;
  logic                     presReset;
  logic [1:0]               pinRise;
  logic [1:0]               pinFall;
  logic                     tick0;
  logic                     cmpSet;
  logic                     ovfSet;
  logic [31:0]              nxt_prdata;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // one wait state: read data is captured on the same edge that raises pready
  assign apbSetup = psel && penable && !pready_ff;
  assign apbDone  = psel && penable && pready_ff;
  assign apbWr    = apbDone && pwrite && addrMapped(paddr);
  assign wrCount  = apbWr && (paddr == `OFS_COUNT);
  assign wrFlags  = apbWr && (paddr == `OFS_FLAGS);
  // [R12] strobe only pulses
  assign presReset = apbWr && (paddr == `OFS_SFC) && pwdata[`BIT_PRES_RST];

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      `OFS_COUNT:   nxt_prdata[7:0] = count_ff;
      `OFS_COMPARE: nxt_prdata[7:0] = compare_ff;
      `OFS_MASK:    nxt_prdata[7:0] = mask_ff;
      `OFS_FLAGS: begin
        nxt_prdata[`BIT_OVF] = ovfFlag_ff;
        nxt_prdata[`BIT_CMP] = cmpFlag_ff;
      end
      // [R12] strobe reads zero
      `OFS_SFC:     nxt_prdata = 32'h0000_0000;
      `OFS_T0_CTRL: begin
        nxt_prdata[2:0]            = sel0_ff;
        nxt_prdata[`BIT_PHASE_PWM] = phasePwm_ff;
      end
      `OFS_T1_CTRL: nxt_prdata[2:0] = sel1_ff;
      default:      nxt_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= apbSetup;
      pslverr_ff <= apbSetup && !addrMapped(paddr);
      if (apbSetup && !pwrite) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      compare_ff  <= `RST_BYTE;
      mask_ff     <= `RST_BYTE;
      sel0_ff     <= timer0_pkg::CS_STOP;
      sel1_ff     <= timer0_pkg::CS_STOP;
      phasePwm_ff <= 1'b0;
    end else if (apbWr) begin
      if (paddr == `OFS_COMPARE) begin
        compare_ff <= pwdata[7:0];
      end
      if (paddr == `OFS_MASK) begin
        mask_ff <= pwdata[7:0];
      end
      // [R8] independent selects
      if (paddr == `OFS_T0_CTRL) begin
        sel0_ff     <= timer0_pkg::clk_sel_e'(pwdata[2:0]);
        phasePwm_ff <= pwdata[`BIT_PHASE_PWM];
      end
      if (paddr == `OFS_T1_CTRL) begin
        sel1_ff <= timer0_pkg::clk_sel_e'(pwdata[2:0]);
      end
    end
  end

  // ----------------------------------------
  // shared prescaler
  // ----------------------------------------
  // [R11] free running divider
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pres_ff <= `RST_PRES;
    end else if (presReset) begin
      pres_ff <= `RST_PRES;
    end else begin
      pres_ff <= pres_ff + 1'b1;
    end
  end

  // ----------------------------------------
  // pin synchroniser and edge detect
  // ----------------------------------------
  // [R13] sampled every clock, pinS1 feeds only pinS2
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pinS1_ff <= 2'h0;
      pinS2_ff <= 2'h0;
      pinS3_ff <= 2'h0;
    end else begin
      pinS1_ff <= {extCountPinB, extCountPinA};
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
    end
  end

  // [R20] pin direction plays no part here
  // [R14] one edge, one tick
  assign pinRise = pinS2_ff & ~pinS3_ff;
  assign pinFall = ~pinS2_ff & pinS3_ff;

  // ----------------------------------------
  // tick selection
  // ----------------------------------------
  // [R10] taps, [R18] pin edges undivided
  assign tick0 = clkTick(sel0_ff, pres_ff, pinRise[0], pinFall[0]);

  // [R8] second timer on same prescaler
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer1Tick_ff <= 1'b0;
    end else begin
      timer1Tick_ff <= clkTick(sel1_ff, pres_ff, pinRise[1], pinFall[1]);
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // [R5] overflow at max, or reversal at bottom in phase mode
  assign ovfSet = tick0 && !wrCount && (phasePwm_ff
                ? (countDown_ff && count_ff == `COUNT_BOTTOM)
                : (count_ff == `COUNT_MAX));
  // [R2] [R1] compare unless blocked by a count write
  assign cmpSet = tick0 && !wrCount && !blockMatch_ff && (count_ff == compare_ff);

  // [R15] comb tick from pinS2 gives roughly three cycles
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_ff     <= `RST_BYTE;
      countDown_ff <= 1'b0;
    end else if (wrCount) begin
      count_ff <= pwdata[7:0];
    end else if (tick0) begin
      if (!phasePwm_ff) begin
        count_ff     <= count_ff + 1'b1;
        countDown_ff <= 1'b0;
      end else if (countDown_ff) begin
        if (count_ff == `COUNT_BOTTOM) begin
          countDown_ff <= 1'b0;
          count_ff     <= count_ff + 1'b1;
        end else begin
          count_ff <= count_ff - 1'b1;
        end
      end else begin
        if (count_ff == `COUNT_MAX) begin
          countDown_ff <= 1'b1;
          count_ff     <= count_ff - 1'b1;
        end else begin
          count_ff <= count_ff + 1'b1;
        end
      end
    end
  end

  // [R1] block held until the next tick
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      blockMatch_ff <= 1'b0;
    end else if (wrCount) begin
      blockMatch_ff <= 1'b1;
    end else if (tick0) begin
      blockMatch_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  // set beats a same-cycle clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ovfFlag_ff <= 1'b0;
      cmpFlag_ff <= 1'b0;
    end else begin
      // [R6] vector or written one clears
      if (ovfSet) begin
        ovfFlag_ff <= 1'b1;
      end else if (ovfVectorAck || (wrFlags && pwdata[`BIT_OVF])) begin
        ovfFlag_ff <= 1'b0;
      end
      // [R7] compare flag set and clear
      if (cmpSet) begin
        cmpFlag_ff <= 1'b1;
      end else if (cmpVectorAck || (wrFlags && pwdata[`BIT_CMP])) begin
        cmpFlag_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // requests and compare pin
  // ----------------------------------------
  // [R3] [R4] [R21] flag and mask, global enable stays in the cpu
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ovfIrq_ff <= 1'b0;
      cmpIrq_ff <= 1'b0;
    end else begin
      ovfIrq_ff <= ovfFlag_ff && mask_ff[`BIT_OVF];
      cmpIrq_ff <= cmpFlag_ff && mask_ff[`BIT_CMP];
    end
  end

  // [R2] pin toggles on each match; waveform modes live elsewhere
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmpPin_ff <= 1'b0;
    end else if (cmpSet) begin
      cmpPin_ff <= !cmpPin_ff;
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign ovfIrq           = ovfIrq_ff;
  assign cmpIrq           = cmpIrq_ff;
  assign compareOutputPin = cmpPin_ff;
  assign timer1Tick       = timer1Tick_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence pinRoseSeq;
    pinS2_ff[0] && !pinS3_ff[0];
  endsequence

  sequence countWriteSeq;
    wrCount ##1 !wrCount;
  endsequence

  presc_clear_a: assert property (presReset |=> pres_ff == `RST_PRES) // R12
    else $error("prescaler not cleared by strobe");
  strobe_readzero_a: assert property (apbSetup && !pwrite && paddr == `OFS_SFC |=> prdata_ff == 32'h0000_0000) // R12
    else $error("strobe bit read non-zero");
  match_block_a: assert property (countWriteSeq ##0 (tick0 && count_ff == compare_ff) |-> !cmpSet) // R1
    else $error("compare match after count write");
  cmp_flagset_a: assert property (cmpSet |=> cmpFlag_ff && (cmpPin_ff != $past(cmpPin_ff))) // R2
    else $error("match did not set flag and pin");
  ovf_request_a: assert property (ovfFlag_ff && mask_ff[`BIT_OVF] |=> ovfIrq_ff) // R3
    else $error("overflow request missing");
  cmp_request_a: assert property (##1 cmpIrq_ff == $past(cmpFlag_ff && mask_ff[`BIT_CMP])) // R4
    else $error("compare request wrong");
  ovf_wrap_a: assert property (tick0 && !phasePwm_ff && !wrCount && count_ff == `COUNT_MAX
    |=> ovfFlag_ff && count_ff == `COUNT_BOTTOM) // R5
    else $error("overflow not flagged on wrap");
  ovf_ackclear_a: assert property (ovfVectorAck && !ovfSet |=> !ovfFlag_ff) // R6
    else $error("overflow flag not cleared");
  direct_tick_a: assert property (sel0_ff == timer0_pkg::CS_DIRECT |-> tick0) // R9
    else $error("direct select did not tick");
  div8_tick_a: assert property (sel0_ff == timer0_pkg::CS_DIV8 && tick0 |-> pres_ff[2:0] == 3'h7) // R10
    else $error("div8 tick off phase");
  rise_tick_a: assert property (pinRoseSeq ##0 sel0_ff == timer0_pkg::CS_RISE |-> tick0) // R14
    else $error("rising pin edge lost");

endmodule : timer0_flags_prescaler

`default_nettype wire

// ### testbench/ext_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none

module ext_pulse_src (
  input  wire logic mclk,
  output logic      pinA,
  output logic      pinB
);
  initial begin
    pinA = 1'b0;
    pinB = 1'b0;
  end

  // ----------------------------------------
  // pulse bursts
  // ----------------------------------------
  // half period kept above one cycle
  task automatic burst(input bit toB, input int n, input int half);
    for (int i = 0; i < 2 * n; i++) begin
      repeat (half) @(posedge mclk);
      if (toB) pinB <= ~pinB;
      else pinA <= ~pinA;
    end
    // pin stays stable before any select change
    // six edges: the last pin edge is counted well before the caller looks
    repeat (6) @(posedge mclk);
  endtask : burst
endmodule : ext_pulse_src

`default_nettype wire

// ### testbench/timer0_flags_and_shared_prescaler_tb_top.sv
`include "timer0_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module timer0_flags_and_shared_prescaler_tb_top;
  logic        mclk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pinA;
  logic        pinB;
  logic        ovfAck;
  logic        cmpAck;
  logic        ovfIrq;
  logic        cmpIrq;
  logic        cmpPin;
  logic        t1Tick;
  logic [31:0] rd;
  logic        er;
  int          err_count;
  int          n_tests;
  int          cycles;
  int          tickCnt;

  timer0_flags_prescaler timer0_flags_prescaler_i (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extCountPinA(pinA), .extCountPinB(pinB), .ovfVectorAck(ovfAck), .cmpVectorAck(cmpAck),
    .ovfIrq(ovfIrq), .cmpIrq(cmpIrq), .compareOutputPin(cmpPin), .timer1Tick(t1Tick)
  );

  ext_pulse_src ext_pulse_src_i (.mclk(mclk), .pinA(pinA), .pinB(pinB));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (t1Tick === 1'b1) tickCnt++;
    // whole run needs about 13k cycles
    if (cycles == 60000) begin
      err_count++;
      $display("CHECK FAILED %0t timeout", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    apb(1'b0, a, 8'h00);
    chk({er, rd}, {1'b0, 24'h00_0000, exp}, msg);
  endtask : rdchk

  task automatic tick_window(input int n);
    @(posedge mclk);
    #1 tickCnt = 0;
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick_window

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdchk(`OFS_MASK, 8'h00, "mask reset");
    rdchk(`OFS_FLAGS, 8'h00, "flags reset");
    rdchk(`OFS_SFC, 8'h00, "sfc reset");
    apb(1'b0, 8'h1C, 8'h00);
    chk({er, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
    apb(1'b1, `OFS_MASK, 8'hA5);
    rdchk(`OFS_MASK, 8'hA5, "mask rw");
    apb(1'b1, `OFS_COUNT, 8'h7E);
    rdchk(`OFS_COUNT, 8'h7E, "count rw");
    apb(1'b1, `OFS_MASK, 8'h01);
    $display("test reset done");
  endtask : t_reset

  task automatic t_compare();
    apb(1'b1, `OFS_COMPARE, 8'hF5);
    rdchk(`OFS_COMPARE, 8'hF5, "compare rw");
    apb(1'b1, `OFS_COUNT, 8'hF0);
    apb(1'b1, `OFS_T0_CTRL, 8'h01);
    repeat (30) @(posedge mclk);
    apb(1'b1, `OFS_T0_CTRL, 8'h00);
    rdchk(`OFS_FLAGS, 8'h03, "match and overflow flags");
    chk({cmpPin, cmpIrq, ovfIrq}, 3'b110, "pin and irq by mask");
    apb(1'b1, `OFS_MASK, 8'h03);
    repeat (3) @(posedge mclk);
    chk(ovfIrq, 1'b1, "ovf irq enabled");
    apb(1'b1, `OFS_FLAGS, 8'h00);
    rdchk(`OFS_FLAGS, 8'h03, "zero write no effect");
    apb(1'b1, `OFS_FLAGS, 8'h02);
    rdchk(`OFS_FLAGS, 8'h01, "ovf write one clears");
    chk({ovfIrq, cmpIrq}, 2'b01, "ovf irq falls");
    @(posedge mclk);
    cmpAck <= 1'b1;
    @(posedge mclk);
    cmpAck <= 1'b0;
    repeat (3) @(posedge mclk);
    rdchk(`OFS_FLAGS, 8'h00, "cmp ack clears");
    chk(cmpIrq, 1'b0, "cmp irq falls");
    $display("test compare done");
  endtask : t_compare

  task automatic t_block();
    apb(1'b1, `OFS_COMPARE, 8'h10);
    apb(1'b1, `OFS_COUNT, 8'h10);
    apb(1'b1, `OFS_T0_CTRL, 8'h01);
    repeat (10) @(posedge mclk);
    apb(1'b1, `OFS_T0_CTRL, 8'h00);
    rdchk(`OFS_FLAGS, 8'h00, "match blocked after write");
    chk(cmpPin, 1'b1, "pin unchanged");
    $display("test block done");
  endtask : t_block

  task automatic t_phase();
    apb(1'b1, `OFS_COUNT, 8'h10);
    apb(1'b1, `OFS_T0_CTRL, 8'h09);
    repeat (300) @(posedge mclk);
    apb(1'b0, `OFS_FLAGS, 8'h00);
    chk(rd[1], 1'b0, "no ovf at max in phase mode");
    repeat (250) @(posedge mclk);
    apb(1'b1, `OFS_T0_CTRL, 8'h00);
    apb(1'b0, `OFS_FLAGS, 8'h00);
    chk(rd[1], 1'b1, "ovf at bottom reversal");
    @(posedge mclk);
    ovfAck <= 1'b1;
    @(posedge mclk);
    ovfAck <= 1'b0;
    repeat (3) @(posedge mclk);
    apb(1'b0, `OFS_FLAGS, 8'h00);
    chk({rd[1], ovfIrq}, 2'b00, "ovf ack clears");
    $display("test phase done");
  endtask : t_phase

  task automatic t_presc();
    int sh[6];
    sh = '{0, 0, 3, 6, 8, 10};
    apb(1'b1, `OFS_SFC, 8'h01);
    rdchk(`OFS_SFC, 8'h00, "strobe reads zero");
    apb(1'b0, `OFS_COUNT, 8'h00);
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, `OFS_T1_CTRL, c[7:0]);
      tick_window(2048);
      chk(tickCnt, (c == 0) ? 0 : (2048 >> sh[c]), "tap rate");
    end
    rdchk(`OFS_COUNT, rd[7:0], "timer0 apart from timer1");
    $display("test prescaler done");
  endtask : t_presc

  task automatic t_ext();
    apb(1'b1, `OFS_T1_CTRL, 8'h07);
    fork
      ext_pulse_src_i.burst(1'b1, 1, 8);
      begin
        tick_window(8);
        chk(tickCnt, 0, "no tick right after edge");
        repeat (4) @(posedge mclk);
        #1 chk(tickCnt, 1, "tick within latency");
      end
    join
    tick_window(0);
    ext_pulse_src_i.burst(1'b1, 10, 2);
    chk(tickCnt, 10, "rising edges undivided");
    apb(1'b1, `OFS_T1_CTRL, 8'h06);
    tick_window(0);
    ext_pulse_src_i.burst(1'b1, 10, 3);
    chk(tickCnt, 10, "falling edges");
    apb(1'b1, `OFS_T1_CTRL, 8'h00);
    apb(1'b1, `OFS_COUNT, 8'h00);
    apb(1'b1, `OFS_T0_CTRL, 8'h07);
    ext_pulse_src_i.burst(1'b0, 5, 3);
    rdchk(`OFS_COUNT, 8'h05, "timer0 pin count");
    apb(1'b1, `OFS_T0_CTRL, 8'h00);
    $display("test external done");
  endtask : t_ext

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    ovfAck  = 1'b0;
    cmpAck  = 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_compare();
    t_block();
    t_phase();
    t_presc();
    t_ext();
    report_and_stop();
  end
endmodule : timer0_flags_and_shared_prescaler_tb_top

`default_nettype wire
